// [cpu_exception_entry.v]
// Exception and interrupt entry logic of the processor core
// How it works
// - Address error: odd fetch, misaligned word/long, user access to upper half.
// - Address error loads faulting address, code 0x0e0 read or 0x100 write.
// - Any entry saves PC and status, then sets mask, privilege and bank bits.
// - Software trap saves next address, immediate times four, code 0x160.
// - Enabled invalid or zero-divide float fault aborts and vectors to base+0x120.
// - Float trap in a delay slot saves the delayed branch address.
// - Float sticky flags always update and hold; cause flags change per operation.
// - Overflow, underflow, inexact and float transfers never trap.
// - Undefined or user-privileged instruction outside slot: code 0x180, base+0x100.
// - Control load/store, return, TLB load, sleep privileged; global-base forms exempt.
// - Bad slot instruction: code 0x1a0, saves delayed branch address.
// - Any PC-rewriting instruction in a slot is an illegal slot.
// - Break trap code 0x1e0; saves next or own address by break kind.
// - NMI edge with mask bit clear taken first, code 0x1c0, base+0x600.
// - Level interrupt accepted when level exceeds mask; mask itself unchanged.
// - Module levels come from 4-bit fields in two priority registers.
// - Mask bit holds interrupts off, except while sleeping.
// - With mask bit set, breaks suppressed, other exceptions jump to reset address.
// - Exception return restores status and resumes at saved PC.
// - Re-executed types save own or branch address; untaken branch saves slot address.
// - Completed types save next address, or branch target when taken.
// - General exceptions vector to base plus 0x100.
`timescale 1ns/1ps
`include "exc_entry_map.vh"
module cpu_exception_entry (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Retiring instruction from the pipeline
   input wire instr_valid,
   input wire [31:0] instr_pc,
   input wire [31:0] instr_next_pc,
   input wire [31:0] branch_pc,
   input wire in_slot,
   input wire slot_branch_not_taken,
   input wire [15:0] opcode,
   input wire is_ctl_move,
   input wire ctl_move_gbr,
   input wire is_return,
   input wire is_tlb_load,
   input wire is_sleep,
   input wire rewrites_pc,
   input wire is_trap,
   input wire [7:0] trap_imm,
   // Data access of the retiring instruction
   input wire mem_req,
   input wire mem_write,
   input wire [1:0] mem_size,
   input wire [31:0] mem_addr,
   // Floating-point result of the retiring instruction
   input wire fpu_valid,
   input wire fpu_compute,
   input wire [4:0] fpu_cause,
   // Break controller
   input wire break_req,
   input wire break_after,
   // Interrupt sources
   input wire sleeping,
   input wire nmi_pin,
   input wire [3:0] external_level_pins,
   input wire [7:0] module_irq,
   // Redirect to the fetch unit
   output reg redirect_valid,
   output reg [31:0] redirect_pc,
   output reg fpu_abort,
   output reg [31:0] status_word
);
   reg [31:0] vbr_q, vbr_d, spc_q, spc_d, ssr_q, ssr_d, tea_q, tea_d;
   reg [31:0] sr_d, fs_q, fs_d, pra_q, pra_d, prb_q, prb_d;
   reg [11:0] exception_event_code_q, exception_event_code_d, interrupt_event_code_q, interrupt_event_code_d;
   reg [9:0] tra_q, tra_d;
   reg nmi_pend_q, nmi_pend_d, nmi_last_q;
   reg redir_d, abort_d;
   reg [31:0] redir_pc_d;
   reg [31:0] rdata;
   reg hit;
   reg exc, exc_brk, re_exec;
   reg [11:0] exc_code;
   reg [31:0] exc_vec, exc_pc;
   wire [4:0] pins_sync;
   wire nmi_s = pins_sync[4];
   wire [3:0] ext_lvl = pins_sync[3:0];

   pin_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pins({nmi_pin, external_level_pins}),
      .pins_sync(pins_sync)
   );

   // Decode of the retiring instruction
   wire user = ~status_word[`SR_MD];
   wire blocked = status_word[`SR_BL];
   wire [3:0] interrupt_level_mask = status_word[`SR_INTERRUPT_LEVEL_MASK_LSB+3:`SR_INTERRUPT_LEVEL_MASK_LSB];
   wire undef = (opcode[15:12] == 4'hf) && (opcode[3:0] == 4'hf);
   wire priv = (is_ctl_move & ~ctl_move_gbr) | is_return | is_tlb_load | is_sleep;
   wire priv_bad = user & priv;
   wire gen_ill = ~in_slot & (undef | priv_bad);
   wire slot_ill = in_slot & (undef | priv_bad | rewrites_pc);
   wire fetch_ae = instr_pc[0];
   wire data_ae = mem_req & (((mem_size == `SIZE_WORD) & mem_addr[0]) |
      ((mem_size == `SIZE_LONG) & (mem_addr[1:0] != 2'h0)) |
      (user & mem_addr[`USER_LIMIT_BIT]));
   // only enabled invalid and zero-divide on compute ops trap
   wire fpu_trap = fpu_valid & fpu_compute &
      ((fpu_cause[`FS_INV] & fs_q[`FS_EN_LSB+`FS_INV]) |
       (fpu_cause[`FS_ZDIV] & fs_q[`FS_EN_LSB+`FS_ZDIV]));
   wire trap = is_trap & ~in_slot;

   // module levels from 4-bit priority fields, highest requester wins
   wire [31:0] prio_fields = {prb_q[15:0], pra_q[15:0]};
   wire [35:0] best_lvl;
   wire [26:0] best_idx;
   assign best_lvl[3:0] = 4'h0;
   assign best_idx[2:0] = 3'h0;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_prio
         localparam [2:0] IDX = g;
         wire [3:0] lvl = module_irq[g] ? prio_fields[4*g+3:4*g] : 4'h0;
         wire win = lvl > best_lvl[4*g+3:4*g];
         assign best_lvl[4*g+7:4*g+4] = win ? lvl : best_lvl[4*g+3:4*g];
         assign best_idx[3*g+5:3*g+3] = win ? IDX : best_idx[3*g+2:3*g];
      end
   endgenerate
   wire [3:0] mod_lvl = best_lvl[35:32];
   wire [2:0] mod_idx = best_idx[26:24];
   wire ext_wins = ext_lvl >= mod_lvl;
   wire [3:0] irq_lvl = ext_wins ? ext_lvl : mod_lvl;
   wire [11:0] irq_code = ext_wins ? (`CODE_EXT_BASE + {3'h0, ext_lvl, 5'h00}) :
      (`CODE_MOD_BASE + {4'h0, mod_idx, 5'h00});

   // APB: one wait state, so answers stand in a register
   wire apb_done = psel & penable & pready;
   wire apb_wr = apb_done & pwrite & ~pslverr;

   always @* begin
      hit = 1'b1;
      case (paddr)
         `OFF_STATUS_WORD: rdata = status_word;
         `OFF_VECTOR_BASE: rdata = vbr_q;
         `OFF_SAVED_PC: rdata = spc_q;
         `OFF_SAVED_STATUS: rdata = ssr_q;
         `OFF_EXC_EVENT: rdata = {20'h00000, exception_event_code_q};
         `OFF_INT_EVENT: rdata = {20'h00000, interrupt_event_code_q};
         `OFF_FAULT_ADDR: rdata = tea_q;
         `OFF_SW_VECTOR: rdata = {22'h000000, tra_q};
         `OFF_FLOAT_STAT: rdata = fs_q;
         `OFF_PRIO_A: rdata = pra_q;
         `OFF_PRIO_B: rdata = prb_q;
         `OFF_PENDING: rdata = {20'h00000, module_irq, ext_lvl} | {nmi_pend_q, 31'h0};
         default: begin
            rdata = 32'h00000000;
            hit = 1'b0;
         end
      endcase
   end

   // Exception selection in fixed priority; result also drives the saved PC
   always @* begin
      exc = 1'b1;
      exc_brk = 1'b0;
      re_exec = 1'b1;
      exc_code = `CODE_ILLEGAL;
      exc_vec = `VEC_GENERAL;
      if (fetch_ae) begin
         exc_code = `CODE_ADDR_RD;
      end else if (slot_ill) begin
         exc_code = `CODE_SLOT;
      end else if (gen_ill) begin
         exc_code = `CODE_ILLEGAL;
      end else if (trap) begin
         exc_code = `CODE_TRAP;
         re_exec = 1'b0;
      end else if (fpu_trap) begin
         exc_code = `CODE_ILLEGAL;
         exc_vec = `VEC_FLOAT;
      end else if (data_ae) begin
         exc_code = mem_write ? `CODE_ADDR_WR : `CODE_ADDR_RD;
      end else if (break_req & ~blocked) begin
         exc_code = `CODE_BREAK;
         exc_brk = 1'b1;
         re_exec = ~break_after;
      end else begin
         exc = 1'b0;
      end
      exc = exc & instr_valid;
      // re-executed types; slot saves branch address
      if (re_exec) begin
         exc_pc = (in_slot & ~slot_branch_not_taken) ? branch_pc : instr_pc;
      end else begin
         // pipeline supplies next address or taken branch target
         exc_pc = instr_next_pc;
      end
   end

   wire int_ok = ~blocked | sleeping;
   wire boundary = (instr_valid & ~is_return) | sleeping;
   wire nmi_edge = nmi_s & ~nmi_last_q;

   always @* begin
      sr_d = status_word;
      vbr_d = vbr_q;
      spc_d = spc_q;
      ssr_d = ssr_q;
      tea_d = tea_q;
      exception_event_code_d = exception_event_code_q;
      interrupt_event_code_d = interrupt_event_code_q;
      tra_d = tra_q;
      fs_d = fs_q;
      pra_d = pra_q;
      prb_d = prb_q;
      redir_d = 1'b0;
      redir_pc_d = redirect_pc;
      abort_d = 1'b0;
      nmi_pend_d = nmi_pend_q;
      if (apb_wr) begin
         case (paddr)
            `OFF_STATUS_WORD: sr_d = pwdata;
            `OFF_VECTOR_BASE: vbr_d = pwdata;
            `OFF_SAVED_PC: spc_d = pwdata;
            `OFF_SAVED_STATUS: ssr_d = pwdata;
            `OFF_EXC_EVENT: exception_event_code_d = pwdata[11:0];
            `OFF_INT_EVENT: interrupt_event_code_d = pwdata[11:0];
            `OFF_FAULT_ADDR: tea_d = pwdata;
            `OFF_SW_VECTOR: tra_d = pwdata[9:0];
            `OFF_FLOAT_STAT: fs_d = pwdata;
            `OFF_PRIO_A: pra_d = {16'h0000, pwdata[15:0]};
            `OFF_PRIO_B: prb_d = {16'h0000, pwdata[15:0]};
            default: nmi_pend_d = nmi_pend_q;
         endcase
      end
      // causes follow each float op, sticky flags accumulate; set beats clear
      if (instr_valid & fpu_valid) begin
         fs_d[`FS_CAUSE_LSB+4:`FS_CAUSE_LSB] = fpu_cause;
         fs_d[`FS_FLAG_LSB+4:`FS_FLAG_LSB] = fs_d[`FS_FLAG_LSB+4:`FS_FLAG_LSB] | fpu_cause;
      end
      // NMI edge is latched until taken, even across the mask bit
      if (nmi_edge) begin
         nmi_pend_d = 1'b1;
      end
      if (exc) begin
         redir_d = 1'b1;
         abort_d = fpu_trap;
         if (blocked) begin
            // nested exception goes to reset address, state left as is
            redir_pc_d = `RESET_ADDR;
         end else begin
            spc_d = exc_pc;
            ssr_d = status_word;
            sr_d = status_word;
            sr_d[`SR_BL] = 1'b1;
            sr_d[`SR_MD] = 1'b1;
            sr_d[`SR_RB] = 1'b1;
            exception_event_code_d = exc_code;
            redir_pc_d = vbr_q + exc_vec;
            if (fetch_ae) begin
               tea_d = instr_pc;
            end else if (data_ae & ~slot_ill & ~gen_ill & ~trap & ~fpu_trap) begin
               tea_d = mem_addr;
            end
            if (trap & ~slot_ill & ~gen_ill & ~fetch_ae) begin
               tra_d = {trap_imm, 2'b00};
            end
         end
      end else if (instr_valid & is_return) begin
         sr_d = ssr_q;
         redir_d = 1'b1;
         redir_pc_d = spc_q;
      end else if (boundary & int_ok & (nmi_pend_q | (irq_lvl > interrupt_level_mask))) begin
         // interrupts only when no exception was taken
         // mask bit holds off, sleep overrides
         redir_d = 1'b1;
         spc_d = instr_next_pc;
         ssr_d = status_word;
         sr_d = status_word;
         sr_d[`SR_BL] = 1'b1;
         sr_d[`SR_MD] = 1'b1;
         sr_d[`SR_RB] = 1'b1;
         redir_pc_d = vbr_q + `VEC_INTERRUPT;
         if (nmi_pend_q) begin
            // NMI first regardless of level mask
            interrupt_event_code_d = `CODE_NMI;
            nmi_pend_d = nmi_edge;
         end else begin
            // level code recorded, mask field untouched
            interrupt_event_code_d = irq_code;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_word <= `SR_RESET;
         vbr_q <= 32'h00000000;
         spc_q <= 32'h00000000;
         ssr_q <= 32'h00000000;
         tea_q <= 32'h00000000;
         exception_event_code_q <= 12'h000;
         interrupt_event_code_q <= 12'h000;
         tra_q <= 10'h000;
         fs_q <= 32'h00000000;
         pra_q <= 32'h00000000;
         prb_q <= 32'h00000000;
         nmi_pend_q <= 1'b0;
         nmi_last_q <= 1'b0;
         redirect_valid <= 1'b0;
         redirect_pc <= `RESET_ADDR;
         fpu_abort <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         status_word <= sr_d;
         vbr_q <= vbr_d;
         spc_q <= spc_d;
         ssr_q <= ssr_d;
         tea_q <= tea_d;
         exception_event_code_q <= exception_event_code_d;
         interrupt_event_code_q <= interrupt_event_code_d;
         tra_q <= tra_d;
         fs_q <= fs_d;
         pra_q <= pra_d;
         prb_q <= prb_d;
         nmi_pend_q <= nmi_pend_d;
         nmi_last_q <= nmi_s;
         redirect_valid <= redir_d;
         redirect_pc <= redir_pc_d;
         fpu_abort <= abort_d;
         if (psel & penable & ~pready) begin
            pready <= 1'b1;
            pslverr <= ~hit;
            prdata <= pwrite ? 32'h00000000 : rdata;
         end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
         end
      end
   end
endmodule

// [cpu_exception_entry_sva.sv]
// Assertion checker on the exception entry unit ports
`timescale 1ns/1ps
`include "exc_entry_map.vh"
module cpu_exception_entry_sva (
   // Clock, reset and APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   // Retiring instruction
   input wire logic instr_valid,
   input wire logic [31:0] instr_pc,
   input wire logic [15:0] opcode,
   input wire logic mem_req,
   input wire logic is_trap,
   input wire logic is_return,
   input wire logic rewrites_pc,
   input wire logic is_ctl_move,
   input wire logic is_tlb_load,
   input wire logic is_sleep,
   input wire logic fpu_valid,
   input wire logic fpu_compute,
   input wire logic [4:0] fpu_cause,
   input wire logic break_req,
   // Interrupts and redirect
   input wire logic sleeping,
   input wire logic nmi_pin,
   input wire logic redirect_valid,
   input wire logic [31:0] redirect_pc,
   input wire logic fpu_abort,
   input wire logic [31:0] status_word
);
   logic [31:0] vbr_q;
   logic [1:0] fen_q;
   wire wr_done = psel && penable && pready && pwrite;
   wire bl = status_word[`SR_BL];
   // No cause besides the one under test
   wire plain = instr_valid && !mem_req && !is_trap && !is_return && !rewrites_pc && !is_ctl_move
      && !is_tlb_load && !is_sleep && !(opcode[15:12] == 4'hf && opcode[3:0] == 4'hf)
      && !sleeping && !instr_pc[0];
   wire ftrap = instr_valid && fpu_valid && fpu_compute && |(fpu_cause[4:3] & fen_q);
   // Shadow of software-owned fields, as the targets depend on them
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vbr_q <= 32'h0;
         fen_q <= 2'h0;
      end else if (wr_done && paddr == `OFF_VECTOR_BASE) begin
         vbr_q <= pwdata;
      end else if (wr_done && paddr == `OFF_FLOAT_STAT) begin
         fen_q <= pwdata[11:10];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_general;
      redirect_valid && redirect_pc == vbr_q + `VEC_GENERAL && status_word[30:28] == 3'h7;
   endsequence
   a_apb_answer: assert property (psel && penable && !pready |=> pready)
      else $error("access phase not answered");
   a_redirect_pulse: assert property (redirect_valid |=> !redirect_valid)
      else $error("redirect longer than one cycle");
   a_trap_entry: assert property (instr_valid && is_trap && !bl |=> s_general)
      else $error("trap entry wrong");
   a_nested_reset: assert property (
      instr_valid && is_trap && bl && !sleeping |=> redirect_valid && redirect_pc == `RESET_ADDR)
      else $error("nested exception not sent to reset address");
   a_break_quiet: assert property (plain && break_req && bl && !fpu_valid |=> !redirect_valid)
      else $error("break taken with mask bit set");
   a_break_entry: assert property (plain && break_req && !bl && !fpu_valid |=> s_general)
      else $error("break entry wrong");
   a_float_trap: assert property (plain && !break_req && ftrap && !bl
      |=> redirect_valid && fpu_abort && redirect_pc == vbr_q + `VEC_FLOAT)
      else $error("float trap entry wrong");
   a_float_quiet: assert property (!ftrap |=> !fpu_abort)
      else $error("float abort without enabled cause");
   a_mask_hold: assert property (bl && !sleeping && !instr_valid |=> !redirect_valid)
      else $error("interrupt taken while masked");
   a_nmi_sleep: assert property ($rose(nmi_pin) && sleeping
      |-> ##[2:8] (redirect_valid && redirect_pc == vbr_q + `VEC_INTERRUPT))
      else $error("nmi not taken in sleep");
endmodule
bind cpu_exception_entry cpu_exception_entry_sva u_sva (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .instr_valid, .instr_pc,
   .opcode, .mem_req, .is_trap, .is_return, .rewrites_pc, .is_ctl_move, .is_tlb_load, .is_sleep,
   .fpu_valid, .fpu_compute, .fpu_cause, .break_req, .sleeping, .nmi_pin, .redirect_valid,
   .redirect_pc, .fpu_abort, .status_word
);

// [exc_entry_map.vh]
// Offsets, field positions, cause codes and vector offsets for the exception entry unit
`ifndef EXC_ENTRY_MAP_VH
`define EXC_ENTRY_MAP_VH

// APB register byte offsets
`define OFF_STATUS_WORD 12'h000
`define OFF_VECTOR_BASE 12'h004
`define OFF_SAVED_PC 12'h008
`define OFF_SAVED_STATUS 12'h00c
`define OFF_EXC_EVENT 12'h010
`define OFF_INT_EVENT 12'h014
`define OFF_FAULT_ADDR 12'h018
`define OFF_SW_VECTOR 12'h01c
`define OFF_FLOAT_STAT 12'h020
`define OFF_PRIO_A 12'h024
`define OFF_PRIO_B 12'h028
`define OFF_PENDING 12'h02c

// Status word fields
`define SR_MD 30
`define SR_RB 29
`define SR_BL 28
`define SR_INTERRUPT_LEVEL_MASK_LSB 4
`define SR_RESET 32'h700000f0

// Float status/control fields: flags, enables and causes, 5 bits each
// Bit order inside a field: 0 inexact, 1 underflow, 2 overflow, 3 zero divide, 4 invalid
`define FS_FLAG_LSB 2
`define FS_EN_LSB 7
`define FS_CAUSE_LSB 12
`define FS_ZDIV 3
`define FS_INV 4

// Event codes
`define CODE_ADDR_RD 12'h0e0
`define CODE_ADDR_WR 12'h100
`define CODE_TRAP 12'h160
`define CODE_ILLEGAL 12'h180
`define CODE_SLOT 12'h1a0
`define CODE_NMI 12'h1c0
`define CODE_BREAK 12'h1e0
`define CODE_EXT_BASE 12'h200
`define CODE_MOD_BASE 12'h400

// Vector offsets and fixed addresses
`define VEC_GENERAL 32'h00000100
`define VEC_FLOAT 32'h00000120
`define VEC_INTERRUPT 32'h00000600
`define RESET_ADDR 32'ha0000000
`define USER_LIMIT_BIT 31

// Access sizes
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2

`endif

// [irq_ctl_model.sv]
// Behavioural interrupt controller driving the pins of the entry unit
`timescale 1ns/1ps
module irq_ctl_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Requests from the bench
   input wire logic nmi_req,
   input wire logic [3:0] level_req,
   // Pins to the block
   output logic nmi_pin,
   output logic [3:0] external_level_pins
);
   logic [2:0] nmi_cnt_q;
   // Pins move only after an edge; the pulse outlasts the two-flop capture
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_cnt_q <= 3'h0;
         external_level_pins <= 4'h0;
      end else begin
         external_level_pins <= level_req;
         if (nmi_req)
            nmi_cnt_q <= 3'h4;
         else if (nmi_cnt_q != 3'h0)
            nmi_cnt_q <= nmi_cnt_q - 3'h1;
      end
   end
   assign nmi_pin = (nmi_cnt_q != 3'h0);
endmodule

// [pin_sync.v]
// Two-flop synchroniser for the asynchronous interrupt pins
`timescale 1ns/1ps
module pin_sync (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Pins in, synchronised levels out
   input wire [4:0] pins,
   output reg [4:0] pins_sync
);
   reg [4:0] meta_q;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= 5'h00;
         pins_sync <= 5'h00;
      end else begin
         meta_q <= pins;
         pins_sync <= meta_q;
      end
   end
endmodule

// [tb_cpu_exception_entry.sv]
// Self-checking bench for the exception entry unit
`timescale 1ns/1ps
`include "exc_entry_map.vh"
module tb_cpu_exception_entry;
   localparam logic [31:0] VECTOR_BASE = 32'h00004000;
   localparam logic [6:0] TRAP = 7'h01, REWR = 7'h02, CTL = 7'h04, RET = 7'h08;
   localparam logic [6:0] BRK = 7'h10, AFT = 7'h20, SLOT = 7'h40;
   logic pclk, presetn, psel, penable, pwrite, instr_valid, in_slot, rewrites_pc, is_trap;
   logic is_ctl_move, ctl_move_gbr, is_return, mem_req, mem_write, fpu_valid, fpu_compute;
   logic break_req, break_after, sleeping, nmi_req, seen, abort_seen, err;
   logic [31:0] pwdata, instr_pc, mem_addr, rd;
   logic [15:0] opcode;
   logic [11:0] paddr;
   logic [7:0] trap_imm, module_irq;
   logic [4:0] fpu_cause;
   logic [3:0] level_req;
   logic [1:0] mem_size;
   wire [31:0] prdata, redirect_pc, status_word;
   wire [3:0] ext_pins;
   wire pready, pslverr, redirect_valid, fpu_abort, nmi_pin;
   integer errors, tests_run, n;

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   cpu_exception_entry DUT (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .instr_valid, .instr_pc, .instr_next_pc(instr_pc + 32'h2), .branch_pc(instr_pc - 32'h2),
      .in_slot, .slot_branch_not_taken(1'b0), .opcode, .is_ctl_move, .ctl_move_gbr, .is_return,
      .is_tlb_load(1'b0), .is_sleep(1'b0), .rewrites_pc, .is_trap, .trap_imm, .mem_req,
      .mem_write, .mem_size, .mem_addr, .fpu_valid, .fpu_compute, .fpu_cause, .break_req,
      .break_after, .sleeping, .nmi_pin, .external_level_pins(ext_pins), .module_irq,
      .redirect_valid, .redirect_pc, .fpu_abort, .status_word
   );
   irq_ctl_model u_irq (
      .pclk(pclk), .presetn(presetn), .nmi_req(nmi_req), .level_req(level_req),
      .nmi_pin(nmi_pin), .external_level_pins(ext_pins)
   );

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run = tests_run + 1;
      if (g !== e) begin
         errors = errors + 1;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do @(posedge pclk); while (pready !== 1'b1);
      chk("apb answer", 1, pready);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask

   task automatic retire(input logic [31:0] pc, input logic [15:0] op, input logic [6:0] f);
      @(posedge pclk);
      instr_valid <= 1'b1;
      instr_pc <= pc;
      opcode <= op;
      {in_slot, break_after, break_req, is_return, is_ctl_move, rewrites_pc, is_trap} <= f;
      @(posedge pclk);
      instr_valid <= 1'b0;
      #1;
      seen = redirect_valid;
      abort_seen = fpu_abort;
   endtask

   task automatic entry(input string nm, input logic [31:0] vec, input logic [11:0] off,
      input logic [31:0] code, input logic [31:0] saved_program_counter, input logic [31:0] saved_status);
      chk({nm, " taken"}, 1, seen);
      chk({nm, " target"}, VECTOR_BASE + vec, redirect_pc);
      chk({nm, " status"}, saved_status | 32'h70000000, status_word);
      rdchk(off, code, {nm, " code"});
      rdchk(`OFF_SAVED_PC, saved_program_counter, {nm, " saved pc"});
      rdchk(`OFF_SAVED_STATUS, saved_status, {nm, " saved status"});
      // Handler restores the saved status, so the next case is nested only when that status has the mask bit set
      apb(1'b1, `OFF_STATUS_WORD, saved_status);
      $display("test %s done", nm);
   endtask

   task automatic excase(input string nm, input logic [15:0] op, input logic [6:0] f,
      input logic [31:0] code, input logic [31:0] saved_program_counter);
      retire(32'h300, op, f);
      entry(nm, `VEC_GENERAL, `OFF_EXC_EVENT, code, saved_program_counter, 32'h0);
   endtask

   task automatic close_out;
      $display("Counts: %0d comparisons, %0d mismatches", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge pclk);
      errors = errors + 1;
      $display("ERROR watchdog expected end seen timeout");
      close_out;
   end

   initial begin
      errors = 0;
      tests_run = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, instr_valid, in_slot, rewrites_pc, is_trap, is_ctl_move} = 8'h0;
      {ctl_move_gbr, is_return, mem_req, mem_write, fpu_valid, fpu_compute} = 6'h0;
      {break_req, break_after, sleeping, nmi_req} = 4'h0;
      {paddr, pwdata, instr_pc, mem_addr, opcode, trap_imm, module_irq, fpu_cause} = '0;
      {level_req, mem_size} = 6'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(`OFF_STATUS_WORD, `SR_RESET, "status reset");
      apb(1'b0, 12'h030, 32'h0);
      chk("unmapped error", 1, err);
      chk("unmapped data", 0, rd);
      apb(1'b1, `OFF_VECTOR_BASE, VECTOR_BASE);
      apb(1'b1, `OFF_STATUS_WORD, 32'h0);
      $display("test reset done");
      mem_req <= 1'b1;
      mem_size <= `SIZE_LONG;
      mem_addr <= 32'h00001002;
      excase("long misaligned", 16'h0009, 7'h0, `CODE_ADDR_RD, 32'h300);
      rdchk(`OFF_FAULT_ADDR, 32'h00001002, "fault address");
      mem_size <= `SIZE_WORD;
      mem_write <= 1'b1;
      mem_addr <= 32'h80000000;
      excase("user upper write", 16'h0009, 7'h0, `CODE_ADDR_WR, 32'h300);
      mem_req <= 1'b0;
      trap_imm <= 8'h21;
      excase("trap", 16'hc321, TRAP, `CODE_TRAP, 32'h302);
      rdchk(`OFF_SW_VECTOR, 32'h84, "trap vector");
      excase("undefined", 16'hf00f, 7'h0, `CODE_ILLEGAL, 32'h300);
      excase("user control", 16'h400e, CTL, `CODE_ILLEGAL, 32'h300);
      excase("slot undefined", 16'hf00f, SLOT, `CODE_SLOT, 32'h2fe);
      excase("slot branch", 16'h0009, SLOT | REWR, `CODE_SLOT, 32'h2fe);
      excase("break after", 16'h0009, BRK | AFT, `CODE_BREAK, 32'h302);
      excase("break before", 16'h0009, BRK, `CODE_BREAK, 32'h300);
      ctl_move_gbr <= 1'b1;
      retire(32'h300, 16'h401e, CTL);
      chk("global base form", 0, seen);
      ctl_move_gbr <= 1'b0;
      apb(1'b1, `OFF_FLOAT_STAT, 32'h00000400);
      fpu_valid <= 1'b1;
      fpu_compute <= 1'b1;
      fpu_cause <= 5'h08;
      retire(32'h400, 16'hf003, SLOT);
      chk("float abort", 1, abort_seen);
      entry("float slot", `VEC_FLOAT, `OFF_EXC_EVENT, `CODE_ILLEGAL, 32'h3fe, 32'h0);
      rdchk(`OFF_FLOAT_STAT, 32'h00008420, "float zdiv flags");
      fpu_cause <= 5'h04;
      retire(32'h400, 16'hf003, 7'h0);
      chk("overflow quiet", 0, seen);
      rdchk(`OFF_FLOAT_STAT, 32'h00004430, "float sticky");
      fpu_compute <= 1'b0;
      fpu_cause <= 5'h08;
      retire(32'h400, 16'hf03d, 7'h0);
      chk("transfer quiet", 0, seen);
      fpu_valid <= 1'b0;
      apb(1'b1, `OFF_STATUS_WORD, 32'h70000000);
      apb(1'b1, `OFF_SAVED_PC, 32'h00001000);
      apb(1'b1, `OFF_SAVED_STATUS, 32'h00000030);
      retire(32'h500, 16'h002b, RET);
      chk("return taken", 1, seen);
      chk("return target", 32'h1000, redirect_pc);
      chk("return status", 32'h30, status_word);
      level_req <= 4'h2;
      repeat (3) retire(32'h600, 16'h0009, 7'h0);
      chk("level below mask", 0, seen);
      apb(1'b1, `OFF_STATUS_WORD, 32'h10000030);
      level_req <= 4'h5;
      repeat (3) retire(32'h600, 16'h0009, 7'h0);
      chk("mask bit holds", 0, seen);
      apb(1'b1, `OFF_STATUS_WORD, 32'h30);
      retire(32'h700, 16'hc301, TRAP);
      entry("trap first", `VEC_GENERAL, `OFF_EXC_EVENT, `CODE_TRAP, 32'h702, 32'h30);
      retire(32'h800, 16'h0009, 7'h0);
      level_req <= 4'h0;
      entry("level", `VEC_INTERRUPT, `OFF_INT_EVENT, 32'h2a0, 32'h802, 32'h30);
      apb(1'b1, `OFF_PRIO_A, 32'h00000007);
      module_irq <= 8'h01;
      retire(32'h900, 16'h0009, 7'h0);
      module_irq <= 8'h00;
      entry("module", `VEC_INTERRUPT, `OFF_INT_EVENT, `CODE_MOD_BASE, 32'h902, 32'h30);
      apb(1'b1, `OFF_STATUS_WORD, 32'h10000030);
      sleeping <= 1'b1;
      nmi_req <= 1'b1;
      @(posedge pclk);
      nmi_req <= 1'b0;
      n = 0;
      do begin
         @(posedge pclk);
         #1;
         n = n + 1;
      end while (redirect_valid !== 1'b1 && n < 12);
      seen = redirect_valid;
      @(posedge pclk);
      sleeping <= 1'b0;
      entry("nmi", `VEC_INTERRUPT, `OFF_INT_EVENT, `CODE_NMI, 32'h902, 32'h10000030);
      retire(32'ha00, 16'hc301, TRAP);
      chk("nested target", `RESET_ADDR, redirect_pc);
      retire(32'ha00, 16'h0009, BRK);
      chk("break held", 0, seen);
      $display("test nested done");
      close_out;
   end
endmodule
